// [logic/osccs_pkg.sv]
// Package of register map, field layout and timing constants for osccs
package osccs_pkg;

  // ==========================================================
  // Register offsets
  // ==========================================================
  localparam logic [7:0] ADDR_EXT_OSC_CONTROL     = 8'hb1;
  localparam logic [7:0] ADDR_HF_OSC_CONTROL      = 8'hb2;
  localparam logic [7:0] ADDR_HF_OSC_PERIOD_TRIM  = 8'hb3;
  localparam logic [7:0] ADDR_LF_OSC_CONTROL      = 8'he3;
  localparam logic [7:0] ADDR_CLOCK_SELECT        = 8'ha9;
  localparam logic [7:0] ADDR_CAPTURE_CONTROL     = 8'hc8;
  localparam logic [7:0] ADDR_TMR_A_RELOAD_LO     = 8'hca;
  localparam logic [7:0] ADDR_TMR_A_RELOAD_HI     = 8'hcb;
  localparam logic [7:0] ADDR_TMR_B_RELOAD_LO     = 8'h92;
  localparam logic [7:0] ADDR_TMR_B_RELOAD_HI     = 8'h93;
  localparam logic [7:0] ADDR_IRQ_STATUS          = 8'he8;
  localparam logic [7:0] ADDR_IRQ_MASK            = 8'he9;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int HF_ON_BIT        = 7;
  localparam int HF_OK_BIT        = 6;
  localparam int LF_ON_BIT        = 7;
  localparam int LF_STABLE_BIT    = 6;
  localparam int LF_TRIM_LSB      = 2;
  localparam int XTAL_OK_BIT      = 7;
  localparam int EXT_MODE_LSB     = 4;
  localparam int EXT_RANGE_LSB    = 0;

  // Interrupt event bit positions
  localparam int EV_HF_OK   = 0;
  localparam int EV_LF_OK   = 1;
  localparam int EV_XTAL_OK = 2;
  localparam int EV_CAP_A   = 3;
  localparam int EV_CAP_B   = 4;
  localparam int EV_COUNT   = 5;

  // ==========================================================
  // Codes and reset values
  // ==========================================================
  localparam logic [1:0] SRC_HF  = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;
  localparam logic [1:0] SRC_LF  = 2'h2;
  localparam logic [1:0] DIV_BY_8_CODE   = 2'h0;
  localparam logic       HF_ON_RESET     = 1'h1;
  localparam logic [6:0] HF_TRIM_DEFAULT = 7'h40;  // Arbitrary value
  localparam logic [3:0] LF_TRIM_DEFAULT = 4'h8;   // Arbitrary value

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_HZ        = 25000000;
  localparam int LF_NOMINAL_HZ = 80000;
  localparam int LF_HALF_CYC   = CLK_HZ / (2 * LF_NOMINAL_HZ);
  localparam int LF_TRIM_STEP  = 2;
  localparam logic [8:0] LF_BASE_HALF = 9'(LF_HALF_CYC - 8 * LF_TRIM_STEP);
  localparam logic [2:0] LF_STABLE_HALVES = 3'h4;
  localparam int XTAL_SETTLE_EDGES_DEF = 1024;

  // ==========================================================
  // Types
  // ==========================================================
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } osccs_bus_s;

  // Divide-select code to shift: 00 -> /8 ... 11 -> /1
  function automatic logic [1:0] osccs_div_shift(input logic [1:0] code);
    return ~code;
  endfunction

endpackage

// [logic/osccs_top.sv]
// Oscillator and system-clock source control with timer capture
//
// Added by the designer: the address-and-strobe port.
module osccs_top
  import osccs_pkg::*;
#(
  parameter logic [6:0] HF_TRIM_FACTORY   = HF_TRIM_DEFAULT,
  parameter logic [3:0] LF_TRIM_FACTORY   = LF_TRIM_DEFAULT,
  parameter int         XTAL_SETTLE_EDGES = XTAL_SETTLE_EDGES_DEF
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       core_ce,
  input  wire osccs_bus_s bus_req,
  output logic [7:0]      rd_data,
  input  wire logic       ext_osc_clk,
  output logic            ext_osc_in_pin_used,
  output logic            ext_osc_out_pin_used,
  output logic            hf_osc_run,
  output logic [6:0]      hf_trim_out,
  output logic            lf_osc_out,
  output logic            core_clock_tick,
  output logic [1:0]      core_clock_source,
  output logic            irq
);

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic                hf_on;
    logic                hf_ok;
    logic [1:0]          hf_div;
    logic [6:0]          hf_trim;
    logic [2:0]          hf_pre;
    logic                lf_on;
    logic                lf_stable;
    logic [3:0]          lf_trim;
    logic [1:0]          lf_div;
    logic [1:0]          lf_div_live;
    logic [8:0]          lf_cnt;
    logic                lf_raw;
    logic [2:0]          lf_pre;
    logic [2:0]          lf_halves;
    logic                lf_out;
    logic [2:0]          ext_mode;
    logic [2:0]          ext_range;
    logic                ext_s1;
    logic                ext_s2;
    logic                ext_prev;
    logic                ext_half;
    logic                xtal_ok;
    logic [15:0]         xtal_cnt;
    logic [1:0]          clk_sel;
    logic [1:0]          src;
    logic                tick;
    logic [1:0]          cap_en;
    logic [15:0]         tmr_a;
    logic [15:0]         tmr_b;
    logic [15:0]         rl_a;
    logic [15:0]         rl_b;
    logic [EV_COUNT-1:0] irq_stat;
    logic [EV_COUNT-1:0] irq_mask;
    logic                irq;
    logic [7:0]          rd_data;
    logic                pin_in;
    logic                pin_out;
  } osccs_state_s;

  // Reset runs from the high-frequency oscillator divided by eight
  localparam osccs_state_s RST = '{
    hf_on:   HF_ON_RESET,
    hf_div:  DIV_BY_8_CODE,
    hf_trim: HF_TRIM_FACTORY,
    lf_trim: LF_TRIM_FACTORY,
    clk_sel: SRC_HF,
    src:     SRC_HF,
    default: '0
  };

  osccs_state_s st;
  osccs_state_s next_st;

  // ==========================================================
  // Next-state logic
  // ==========================================================
  always_comb begin
    logic [1:0]          hf_sh;
    logic [1:0]          lf_sh;
    logic [2:0]          hf_mask;
    logic [8:0]          lf_half;
    logic                lf_rise_raw;
    logic                lf_fall;
    logic                lf_rise;
    logic                ext_en;
    logic                ext_xtal;
    logic                ext_div2;
    logic                ext_edge;
    logic                ext_tick;
    logic                src_ready;
    logic [EV_COUNT-1:0] ev;
    logic [7:0]          rv;

    next_st     = st;
    hf_sh       = osccs_div_shift(st.hf_div);
    lf_sh       = osccs_div_shift(st.lf_div_live);
    hf_mask     = 3'((4'h1 << hf_sh) - 4'h1);
    lf_half     = LF_BASE_HALF + 9'(st.lf_trim) * 9'(LF_TRIM_STEP);
    lf_rise_raw = 1'b0;
    ev          = '0;
    rv          = 8'h00;
    lf_fall     = 1'b0;
    lf_rise     = 1'b0;
    ext_en      = 1'b0;
    ext_xtal    = 1'b0;
    ext_div2    = 1'b0;
    ext_edge    = 1'b0;
    ext_tick    = 1'b0;
    src_ready   = 1'b0;

    // High-frequency oscillator: ready one cycle after enable
    next_st.hf_ok = st.hf_on;
    if (st.hf_on && !st.hf_ok) begin
      ev[EV_HF_OK] = 1'b1;
    end
    next_st.hf_pre = st.hf_on ? st.hf_pre + 3'h1 : 3'h0;

    // Low-frequency oscillator model: half period grows with trim
    if (st.lf_on) begin
      if (st.lf_cnt >= lf_half) begin
        next_st.lf_cnt = 9'h000;
        next_st.lf_raw = !st.lf_raw;
        lf_rise_raw    = !st.lf_raw;
        // While running, a new divide code takes effect only on an oscillator edge; while off it is taken at once
        next_st.lf_div_live = st.lf_div;
        if (st.lf_halves != LF_STABLE_HALVES) begin
          next_st.lf_halves = st.lf_halves + 3'h1;
        end
      end else begin
        next_st.lf_cnt = st.lf_cnt + 9'h001;
      end
    end else begin
      next_st.lf_cnt    = 9'h000;
      next_st.lf_raw    = 1'b0;
      next_st.lf_halves = 3'h0;
      next_st.lf_div_live = st.lf_div;
    end
    next_st.lf_stable = st.lf_on
                        && (next_st.lf_halves == LF_STABLE_HALVES);
    if (next_st.lf_stable && !st.lf_stable) begin
      ev[EV_LF_OK] = 1'b1;
    end
    if (lf_rise_raw) begin
      next_st.lf_pre = st.lf_pre + 3'h1;
    end
    if (!st.lf_on) begin
      next_st.lf_pre = 3'h0;
    end
    // Post divider 1/2/4/8; switching only on an oscillator edge keeps
    // every output phase at least one oscillator half period long
    lf_sh = osccs_div_shift(next_st.lf_div_live);
    if (lf_sh == 2'h0) begin
      next_st.lf_out = next_st.lf_raw;
    end else begin
      next_st.lf_out = next_st.lf_pre[lf_sh - 2'h1];
    end
    lf_rise = next_st.lf_out && !st.lf_out;
    lf_fall = !next_st.lf_out && st.lf_out;

    // External oscillator: synchronise the pin and find rising edges
    ext_en   = st.ext_mode[2] || (st.ext_mode[2:1] == 2'h1);
    ext_xtal = (st.ext_mode[2:1] == 2'h3);
    ext_div2 = ext_en && st.ext_mode[0] && (st.ext_mode[2:1] != 2'h2);
    // The pin is unrelated to core_clk: two flops before any use
    next_st.ext_s1   = ext_osc_clk;
    next_st.ext_s2   = st.ext_s1;
    next_st.ext_prev = st.ext_s2;
    ext_edge = ext_en && st.ext_s2 && !st.ext_prev;
    if (ext_edge) begin
      next_st.ext_half = !st.ext_half;
    end
    ext_tick = ext_edge && (!ext_div2 || st.ext_half);
    next_st.pin_in  = ext_xtal;
    next_st.pin_out = ext_en;

    // Crystal settling: count oscillator edges after enable
    // Leaving crystal mode drops the flag, so a re-entry waits again
    if (!ext_xtal) begin
      next_st.xtal_cnt = 16'h0000;
      next_st.xtal_ok  = 1'b0;
    end else if (ext_edge && !st.xtal_ok) begin
      next_st.xtal_cnt = st.xtal_cnt + 16'h0001;
      if (st.xtal_cnt == 16'(XTAL_SETTLE_EDGES - 1)) begin
        next_st.xtal_ok = 1'b1;
        ev[EV_XTAL_OK]  = 1'b1;
      end
    end

    // Source switch only to an enabled, settled source
    // An unready request is held; the running source keeps the core going
    unique case (st.clk_sel)
      SRC_HF:  src_ready = st.hf_ok;
      SRC_EXT: src_ready = ext_xtal ? st.xtal_ok : ext_en;
      SRC_LF:  src_ready = st.lf_stable;
      default: src_ready = 1'b0;
    endcase
    if (src_ready) begin
      next_st.src = st.clk_sel;
    end
    // One pulse per period of the active source
    unique case (st.src)
      SRC_HF:  next_st.tick = st.hf_on
                              && ((st.hf_pre & hf_mask) == 3'h0);
      SRC_EXT: next_st.tick = ext_tick;
      SRC_LF:  next_st.tick = lf_rise;
      default: next_st.tick = 1'b0;
    endcase

    // Timers with low-frequency capture
    // Both timers count core cycles, so capture gaps give the LF period
    next_st.tmr_a = st.tmr_a + 16'h0001;
    next_st.tmr_b = st.tmr_b + 16'h0001;
    if (st.cap_en[0] && lf_fall) begin
      next_st.rl_a   = st.tmr_a;
      ev[EV_CAP_A]   = 1'b1;
    end
    if (st.cap_en[1] && lf_rise) begin
      next_st.rl_b   = st.tmr_b;
      ev[EV_CAP_B]   = 1'b1;
    end

    // Register writes
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        ADDR_HF_OSC_CONTROL: begin
          next_st.hf_on  = bus_req.wdata[HF_ON_BIT];
          next_st.hf_div = bus_req.wdata[1:0];
        end
        ADDR_HF_OSC_PERIOD_TRIM: next_st.hf_trim = bus_req.wdata[6:0];
        ADDR_LF_OSC_CONTROL: begin
          next_st.lf_on   = bus_req.wdata[LF_ON_BIT];
          next_st.lf_trim = bus_req.wdata[LF_TRIM_LSB +: 4];
          next_st.lf_div  = bus_req.wdata[1:0];
        end
        // Range is only stored: it tunes the analog drive, not this logic
        ADDR_EXT_OSC_CONTROL: begin
          next_st.ext_mode  = bus_req.wdata[EXT_MODE_LSB +: 3];
          next_st.ext_range = bus_req.wdata[EXT_RANGE_LSB +: 3];
        end
        ADDR_CLOCK_SELECT:    next_st.clk_sel = bus_req.wdata[1:0];
        ADDR_CAPTURE_CONTROL: next_st.cap_en  = bus_req.wdata[1:0];
        ADDR_IRQ_MASK: next_st.irq_mask = bus_req.wdata[EV_COUNT-1:0];
        default: ;
      endcase
    end

    // Sticky events; a new event wins over a write-one clear
    next_st.irq_stat = st.irq_stat;
    if (bus_req.wr && bus_req.addr == ADDR_IRQ_STATUS) begin
      next_st.irq_stat = st.irq_stat & ~bus_req.wdata[EV_COUNT-1:0];
    end
    next_st.irq_stat = next_st.irq_stat | ev;
    // Level output, taken from the values being registered
    next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);

    // Register reads, answered in the next cycle
    // Idle and unmapped reads give zero, so no stale value stands
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        ADDR_HF_OSC_CONTROL:
          rv = {st.hf_on, st.hf_ok, 4'h0, st.hf_div};
        ADDR_HF_OSC_PERIOD_TRIM: rv = {1'b0, st.hf_trim};
        ADDR_LF_OSC_CONTROL:
          rv = {st.lf_on, st.lf_stable, st.lf_trim, st.lf_div};
        ADDR_EXT_OSC_CONTROL:
          rv = {st.xtal_ok, st.ext_mode, 1'b0, st.ext_range};
        ADDR_CLOCK_SELECT:    rv = {2'h0, st.src, 2'h0, st.clk_sel};
        ADDR_CAPTURE_CONTROL: rv = {6'h00, st.cap_en};
        ADDR_TMR_A_RELOAD_LO: rv = st.rl_a[7:0];
        ADDR_TMR_A_RELOAD_HI: rv = st.rl_a[15:8];
        ADDR_TMR_B_RELOAD_LO: rv = st.rl_b[7:0];
        ADDR_TMR_B_RELOAD_HI: rv = st.rl_b[15:8];
        ADDR_IRQ_STATUS:      rv = 8'(st.irq_stat);
        ADDR_IRQ_MASK:        rv = 8'(st.irq_mask);
        default:              rv = 8'h00;
      endcase
    end
    next_st.rd_data = rv;
  end

  // ==========================================================
  // State register
  // ==========================================================
  // Clock enable low freezes every field; bus requests are lost
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= RST;
    end else if (core_ce) begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign rd_data              = st.rd_data;
  assign ext_osc_in_pin_used  = st.pin_in;
  assign ext_osc_out_pin_used = st.pin_out;
  assign hf_osc_run           = st.hf_on;
  assign hf_trim_out          = st.hf_trim;
  assign lf_osc_out           = st.lf_out;
  assign core_clock_tick      = st.tick;
  assign core_clock_source    = st.src;
  assign irq                  = st.irq;

endmodule // osccs_top

// [testbench/osccs_props.sv]
// Port checker of the oscillator and clock source block
module osccs_props
  import osccs_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       core_ce,
  input wire osccs_bus_s bus_req,
  input wire logic [7:0] rd_data,
  input wire logic       ext_osc_clk,
  input wire logic       ext_osc_in_pin_used,
  input wire logic       ext_osc_out_pin_used,
  input wire logic       hf_osc_run,
  input wire logic [6:0] hf_trim_out,
  input wire logic       lf_osc_out,
  input wire logic       core_clock_tick,
  input wire logic [1:0] core_clock_source,
  input wire logic       irq
);
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // Helpers
  // ==========================================================
  logic       cfg_wr;
  logic [1:0] hf_div;
  logic [4:0] quiet;
  logic       lf_q;
  logic [7:0] lf_cnt;

  assign cfg_wr = core_ce && bus_req.wr && (bus_req.addr ==
    ADDR_HF_OSC_CONTROL || bus_req.addr == ADDR_CLOCK_SELECT);

  // Quiet counts cycles since the HF setup or source last moved
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hf_div <= DIV_BY_8_CODE;
      quiet  <= 5'h00;
      lf_q   <= 1'b0;
      lf_cnt <= 8'h00;
    end else begin
      if (cfg_wr && bus_req.addr == ADDR_HF_OSC_CONTROL) begin
        hf_div <= bus_req.wdata[1:0];
      end
      if (cfg_wr || !core_ce || $changed(core_clock_source)) begin
        quiet <= 5'h00;
      end else if (quiet != 5'h1f) begin
        quiet <= quiet + 5'h01;
      end
      lf_q <= lf_osc_out;
      if (lf_osc_out != lf_q) begin
        lf_cnt <= 8'h01;
      end else if (lf_cnt != 8'hff) begin
        lf_cnt <= lf_cnt + 8'h01;
      end
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  reset_source_a: assert property (
    $fell(sys_rst) |-> core_clock_source == SRC_HF && hf_osc_run)
    else $error("source or HF enable wrong after reset");
  hf_enable_a: assert property (
    cfg_wr && bus_req.addr == ADDR_HF_OSC_CONTROL
    |=> hf_osc_run == $past(bus_req.wdata[7]))
    else $error("HF enable does not follow control bit 7");
  trim_write_a: assert property (
    core_ce && bus_req.wr && bus_req.addr == ADDR_HF_OSC_PERIOD_TRIM
    |=> hf_trim_out == $past(bus_req.wdata[6:0]))
    else $error("period trim not taken");
  div_eight_a: assert property (
    @(posedge core_clk) disable iff (sys_rst || cfg_wr)
    quiet > 5'h0f && hf_div == 2'h0 && core_clock_source == SRC_HF
    && hf_osc_run && core_clock_tick
    |=> !core_clock_tick [*7] ##1 core_clock_tick)
    else $error("HF divide by 8 tick spacing wrong");
  no_code3_a: assert property (
    core_clock_source != 2'h3)
    else $error("reserved source code became active");
  hf_switch_a: assert property (
    core_ce && bus_req.wr && bus_req.addr == ADDR_CLOCK_SELECT
    && bus_req.wdata[1:0] == SRC_HF && hf_osc_run
    |-> ##2 core_clock_source == SRC_HF)
    else $error("switch to enabled HF oscillator late");
  xtal_pins_a: assert property (
    ext_osc_in_pin_used |-> ext_osc_out_pin_used)
    else $error("first oscillator pin taken without the second");
  lf_half_a: assert property (
    lf_osc_out != lf_q |-> lf_cnt >= 8'h8c)
    else $error("LF output half period below fastest setting");
endmodule // osccs_props

bind osccs_top osccs_props u_props (
  .core_clk(core_clk), .sys_rst(sys_rst), .core_ce(core_ce),
  .bus_req(bus_req), .rd_data(rd_data), .ext_osc_clk(ext_osc_clk),
  .ext_osc_in_pin_used(ext_osc_in_pin_used),
  .ext_osc_out_pin_used(ext_osc_out_pin_used),
  .hf_osc_run(hf_osc_run), .hf_trim_out(hf_trim_out),
  .lf_osc_out(lf_osc_out), .core_clock_tick(core_clock_tick),
  .core_clock_source(core_clock_source), .irq(irq));

// [testbench/osccs_ext_osc_model.sv]
// External oscillator model: runs only while its pin is taken
module osccs_ext_osc_model #(
  parameter int HALF_NS = 100
) (
  input  wire logic osc_on,
  input  wire logic slow,
  output logic      osc_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial osc_out = 1'b0;
  // Pin rests low while the drive circuit is off
  always begin
    #(slow ? 2 * HALF_NS : HALF_NS);
    osc_out = osc_on ? ~osc_out : 1'b0;
  end
endmodule // osccs_ext_osc_model

// [testbench/tb_osc_clock_source_control.sv]
// Self-checking bench of the oscillator and clock source block
module tb_osc_clock_source_control
  import osccs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk = 1'b0;
  logic       sys_rst  = 1'b1;
  logic       core_ce  = 1'b1;
  osccs_bus_s bus_req  = '0;
  logic       slow     = 1'b0;
  logic [7:0] rd_data;
  logic       ext_clk, pin_in, pin_out, hf_run, lf_out, tick, irq;
  logic [6:0] trim_out;
  logic [1:0] src;
  int         n_mismatch = 0;
  int         cmp_count  = 0;

  always #20 core_clk = ~core_clk;

  osccs_top #(.XTAL_SETTLE_EDGES(4)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .core_ce(core_ce),
    .bus_req(bus_req), .rd_data(rd_data), .ext_osc_clk(ext_clk),
    .ext_osc_in_pin_used(pin_in), .ext_osc_out_pin_used(pin_out),
    .hf_osc_run(hf_run), .hf_trim_out(trim_out), .lf_osc_out(lf_out),
    .core_clock_tick(tick), .core_clock_source(src), .irq(irq));
  osccs_ext_osc_model #(.HALF_NS(100)) xosc (
    .osc_on(pin_out), .slow(slow), .osc_out(ext_clk));

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic print_verdict();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1 d = {8'h00, rd_data};
  endtask
  task automatic rchk(input logic [7:0] a, exp, input string what);
    logic [15:0] d;
    rd(a, d);
    chk(d, {8'h00, exp}, what);
  endtask
  task automatic cap(input logic [7:0] a, output logic [15:0] v);
    logic [15:0] lo;
    logic [15:0] hi;
    cyc(4);
    rd(a, lo);
    rd(a + 8'h01, hi);
    v = {hi[7:0], lo[7:0]};
  endtask
  task automatic lf_edge(input logic to, output int n);
    n = 0;
    while (lf_out !== to) begin
      cyc(1);
      n++;
      if (n > 3000) begin
        n_mismatch++;
        print_verdict();
      end
    end
  endtask
  task automatic ticks(input int k, output int n);
    n = 0;
    repeat (k) begin
      cyc(1);
      n += int'(tick === 1'b1);
    end
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    logic [15:0] a1;
    logic [15:0] a2;
    logic [15:0] b1;
    int          n;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    chk(16'(src), 16'(SRC_HF), "source");
    rchk(ADDR_HF_OSC_CONTROL, 8'hc0, "hf_ctl");
    rchk(ADDR_HF_OSC_PERIOD_TRIM, 8'h40, "hf_trim");
    rchk(ADDR_LF_OSC_CONTROL, 8'h20, "lf_ctl");
    rchk(ADDR_EXT_OSC_CONTROL, 8'h00, "ext_ctl");
    rchk(8'h00, 8'h00, "unmapped");
    wr(ADDR_HF_OSC_PERIOD_TRIM, 8'h95);
    chk(16'(trim_out), 16'h0015, "trim_out");
    rchk(ADDR_HF_OSC_PERIOD_TRIM, 8'h15, "trim_rd");
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_HF_OSC_CONTROL, 8'h80 | 8'(c));
      cyc(20);
      ticks(64, n);
      chk(16'(n), 16'(8 << c), "hf_ticks");
    end
    wr(ADDR_HF_OSC_CONTROL, 8'h7f);
    chk(16'(hf_run), 16'h0000, "hf_run");
    rchk(ADDR_HF_OSC_CONTROL, 8'h03, "hf_off");
    wr(ADDR_HF_OSC_CONTROL, 8'h80);
    rchk(ADDR_HF_OSC_CONTROL, 8'hc0, "hf_on");
    wr(ADDR_LF_OSC_CONTROL, 8'h83);
    lf_edge(1'b1, n);
    lf_edge(1'b0, n);
    lf_edge(1'b1, n);
    chk(16'(n), 16'h008d, "lf_fast");
    lf_edge(1'b0, n);
    rchk(ADDR_LF_OSC_CONTROL, 8'hc3, "lf_stable");
    wr(ADDR_LF_OSC_CONTROL, 8'hbc);
    lf_edge(1'b0, n);
    lf_edge(1'b1, n);
    lf_edge(1'b0, n);
    chk(16'(n), 16'h0558, "lf_slow");
    wr(ADDR_IRQ_STATUS, 8'h1f);
    wr(ADDR_IRQ_MASK, 8'h08);
    wr(ADDR_CAPTURE_CONTROL, 8'h03);
    lf_edge(1'b1, n);
    lf_edge(1'b0, n);
    cyc(4);
    chk(16'(irq), 16'h0001, "irq_set");
    cap(ADDR_TMR_A_RELOAD_LO, a1);
    lf_edge(1'b1, n);
    cap(ADDR_TMR_B_RELOAD_LO, b1);
    lf_edge(1'b0, n);
    cap(ADDR_TMR_A_RELOAD_LO, a2);
    chk(b1 - a1, 16'h0558, "cap_low");
    chk(a2 - a1, 16'h0ab0, "cap_period");
    wr(ADDR_IRQ_MASK, 8'h00);
    cyc(2);
    chk(16'(irq), 16'h0000, "irq_masked");
    wr(ADDR_IRQ_MASK, 8'h08);
    cyc(2);
    chk(16'(irq), 16'h0001, "irq_unmasked");
    wr(ADDR_IRQ_STATUS, 8'h08);
    cyc(2);
    chk(16'(irq), 16'h0000, "irq_cleared");
    wr(ADDR_CLOCK_SELECT, {6'h00, SRC_LF});
    cyc(2);
    chk(16'(src), 16'(SRC_LF), "src_lf");
    rchk(ADDR_CLOCK_SELECT, 8'h22, "clk_sel");
    // A write while the clock enable is low must be lost
    @(posedge core_clk);
    core_ce <= 1'b0;
    wr(ADDR_HF_OSC_PERIOD_TRIM, 8'h22);
    @(posedge core_clk);
    core_ce <= 1'b1;
    rchk(ADDR_HF_OSC_PERIOD_TRIM, 8'h15, "ce_frozen");
    // Type and range are set before the external source is chosen
    wr(ADDR_EXT_OSC_CONTROL, 8'h67);
    rchk(ADDR_EXT_OSC_CONTROL, 8'h67, "xtal_wait");
    wr(ADDR_CLOCK_SELECT, {6'h00, SRC_EXT});
    cyc(2);
    chk(16'(src), 16'(SRC_LF), "src_hold");
    cyc(60);
    chk(16'(src), 16'(SRC_EXT), "src_ext");
    chk(16'({pin_in, pin_out}), 16'h0003, "xtal_pins");
    rchk(ADDR_EXT_OSC_CONTROL, 8'he7, "xtal_ok");
    rchk(ADDR_IRQ_STATUS, 8'h14, "irq_stat");
    ticks(100, n);
    chk(16'(n > 18 && n < 22), 16'h0001, "ext_ticks");
    slow <= 1'b1;
    wr(ADDR_EXT_OSC_CONTROL, 8'h20);
    cyc(20);
    chk(16'({pin_in, pin_out}), 16'h0001, "cmos_pins");
    ticks(200, n);
    chk(16'(n > 18 && n < 22), 16'h0001, "cmos_ticks");
    wr(ADDR_CLOCK_SELECT, 8'h03);
    cyc(4);
    chk(16'(src), 16'(SRC_EXT), "src_code3");
    wr(ADDR_CLOCK_SELECT, {6'h00, SRC_HF});
    cyc(2);
    chk(16'(src), 16'(SRC_HF), "src_hf");
    print_verdict();
  end
endmodule // tb_osc_clock_source_control
